// ===== rtl/ksd_cfg.svh
// constants of the kernel segment decoder: offsets, fields, resets
`ifndef KSD_CFG_SVH
`define KSD_CFG_SVH

// decode fields
`define KSD_PRIV_KERNEL 2'h0
`define KSD_SEL32_UNCACHED 3'h5
`define KSD_SEL32_SUPER 3'h6
`define KSD_SEL32_MAPPED3 3'h7
`define KSD_UNCACHED32_BASE 32'ha000_0000
`define KSD_DEBUG32_TOP 10'h3fc
`define KSD_REG64_USER 2'h0
`define KSD_REG64_SUPER 2'h1
`define KSD_REG64_PHYS 2'h2
`define KSD_REG64_KERNEL 2'h3
`define KSD_COMPAT_ONES 31'h7fff_ffff
`define KSD_XKSEG_END_HI 9'h1ff
`define KSD_ATTR_WT0 3'h0
`define KSD_ATTR_WT1 3'h1
`define KSD_ATTR_UNCACHED 3'h2
`define KSD_ATTR_CACHED 3'h3

// register map, byte offsets on the 8-bit register address
`define KSD_OFS_STATUS 8'h00
`define KSD_OFS_MASK 8'h04
`define KSD_OFS_CONFIG 8'h08
`define KSD_OFS_ERRLO 8'h0c
`define KSD_OFS_ERRHI 8'h10

// status and mask bit positions
`define KSD_EV_ADDR_ERR 0
`define KSD_EV_RSV_ATTR 1
`define KSD_EV_DEBUG_HIT 2
`define KSD_EV_NOT_KERNEL 3
`define KSD_EV_W 4

// reset values
`define KSD_RST_MASK 4'h0
`define KSD_RST_K0 3'h2

`endif

// ===== rtl/ksd_pkg.sv
// types shared by the kernel segment decoder files
package ksd_pkg;
  `include "ksd_cfg.svh"

  typedef enum logic [3:0] {
    KSD_SEG_NONE,
    KSD_SEG_UNCACHED32,
    KSD_SEG_SUPER32,
    KSD_SEG_MAPPED3_32,
    KSD_SEG_DEBUG,
    KSD_SEG_XUSER,
    KSD_SEG_XUSER_ERL,
    KSD_SEG_XSUPER,
    KSD_SEG_XPHYS,
    KSD_SEG_XKERNEL,
    KSD_SEG_CK0,
    KSD_SEG_CK1,
    KSD_SEG_CKSUPER,
    KSD_SEG_CK3
  } ksd_seg_t;

  // reserved codes fall to uncached
  function automatic logic ksd_attr_cached(input logic [2:0] attr);
    ksd_attr_cached = (attr == `KSD_ATTR_WT0) || (attr == `KSD_ATTR_WT1) ||
                      (attr == `KSD_ATTR_CACHED);
  endfunction
endpackage

// ===== rtl/ksd_seg32.sv
// 32-bit kernel segment decode, combinational
`timescale 1ns/10ps
module ksd_seg32
  import ksd_pkg::*;
(
  input wire logic [63:0] vaddr,
  output ksd_seg_t seg,
  output logic mapped,
  output logic cached,
  output logic [35:0] paddr,
  output logic addr_err
);
  logic [31:0] offset;

  always_comb begin
    offset = vaddr[31:0] - `KSD_UNCACHED32_BASE;
    seg = KSD_SEG_NONE;
    mapped = 1'b0;
    cached = 1'b0;
    paddr = 36'h0;
    // upper word must be the sign of bit 31
    addr_err = vaddr[63:32] != {32{vaddr[31]}};
    case (vaddr[31:29])
      `KSD_SEL32_UNCACHED: begin
        seg = KSD_SEG_UNCACHED32;
        paddr = {4'h0, offset};
        cached = 1'b0;
      end
      `KSD_SEL32_SUPER: begin
        seg = KSD_SEG_SUPER32;
        mapped = 1'b1;
      end
      `KSD_SEL32_MAPPED3: begin
        if (vaddr[31:22] == `KSD_DEBUG32_TOP) begin
          seg = KSD_SEG_DEBUG;
          paddr = {4'h0, vaddr[31:0]};
        end else begin
          seg = KSD_SEG_MAPPED3_32;
          mapped = 1'b1;
        end
      end
      default: begin
        seg = KSD_SEG_NONE;
      end
    endcase
  end
endmodule

// ===== rtl/ksd_seg64.sv
// 64-bit kernel segment decode, combinational
`timescale 1ns/10ps
module ksd_seg64
  import ksd_pkg::*;
(
  input wire logic [63:0] vaddr,
  input wire logic error_level_flag,
  input wire logic [2:0] k0_attr,
  output ksd_seg_t seg,
  output logic mapped,
  output logic cached,
  output logic [2:0] attr,
  output logic [35:0] paddr,
  output logic addr_err,
  output logic rsv_attr
);
  always_comb begin
    seg = KSD_SEG_NONE;
    mapped = 1'b1;
    cached = 1'b0;
    attr = 3'h0;
    paddr = 36'h0;
    addr_err = 1'b0;
    rsv_attr = 1'b0;
    case (vaddr[63:62])
      `KSD_REG64_USER: begin
        if (error_level_flag && vaddr[63:31] == 33'h0) begin
          seg = KSD_SEG_XUSER_ERL;
          mapped = 1'b0;
          attr = `KSD_ATTR_UNCACHED;
          paddr = vaddr[35:0];
        end else begin
          seg = KSD_SEG_XUSER;
          addr_err = |vaddr[61:40];
        end
      end
      `KSD_REG64_SUPER: begin
        seg = KSD_SEG_XSUPER;
        addr_err = |vaddr[61:40];
      end
      `KSD_REG64_PHYS: begin
        seg = KSD_SEG_XPHYS;
        mapped = 1'b0;
        attr = vaddr[61:59];
        cached = ksd_attr_cached(vaddr[61:59]);
        rsv_attr = vaddr[61];
        addr_err = |vaddr[58:36];
        paddr = vaddr[35:0];
      end
      default: begin
        if (vaddr[61:31] == `KSD_COMPAT_ONES) begin
          case (vaddr[30:29])
            2'h0: begin
              seg = KSD_SEG_CK0;
              mapped = 1'b0;
              attr = k0_attr;
              cached = ksd_attr_cached(k0_attr);
              paddr = {7'h0, vaddr[28:0]};
            end
            2'h1: begin
              seg = KSD_SEG_CK1;
              mapped = 1'b0;
              attr = `KSD_ATTR_UNCACHED;
              paddr = {7'h0, vaddr[28:0]};
            end
            2'h2: seg = KSD_SEG_CKSUPER;
            default: begin
              if (vaddr[31:22] == `KSD_DEBUG32_TOP) begin
                seg = KSD_SEG_DEBUG;
                mapped = 1'b0;
                attr = `KSD_ATTR_UNCACHED;
                paddr = {4'h0, vaddr[31:0]};
              end else begin
                seg = KSD_SEG_CK3;
              end
            end
          endcase
        end else begin
          seg = KSD_SEG_XKERNEL;
          addr_err = (|vaddr[61:40]) ||
                     (vaddr[39:31] == `KSD_XKSEG_END_HI);
        end
      end
    endcase
  end
endmodule

// ===== rtl/ksd_top.sv
// kernel segment decoder top: mode select, response stage, registers
`timescale 1ns/10ps
module ksd_top
  import ksd_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic req_valid,
  input wire logic [63:0] vaddr,
  input wire logic [1:0] privilege_field,
  input wire logic exception_level_flag,
  input wire logic error_level_flag,
  input wire logic kernel_wide_addressing,
  input wire logic [7:0] address_space_identifier,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  output logic resp_valid,
  output logic resp_kernel,
  output ksd_seg_t resp_segment,
  output logic resp_mapped,
  output logic resp_cached,
  output logic [2:0] resp_attr,
  output logic [35:0] resp_paddr,
  output logic [63:0] resp_vaddr,
  output logic [7:0] resp_space_id,
  output logic resp_addr_error
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic resp_valid;
    logic resp_kernel;
    ksd_seg_t seg;
    logic mapped;
    logic cached;
    logic [2:0] attr;
    logic [35:0] paddr;
    logic [63:0] vaddr;
    logic [7:0] space_id;
    logic addr_err;
    logic [`KSD_EV_W-1:0] status;
    logic [`KSD_EV_W-1:0] mask;
    logic [2:0] k0_attr;
    logic [63:0] err_vaddr;
    logic [31:0] rdata;
    logic irq;
  } ksd_state_t;

  ksd_state_t st_q;
  ksd_state_t st_d;

  // ************************************************************
  // segment decoders
  // ************************************************************
  ksd_seg_t seg32;
  logic map32;
  logic cac32;
  logic [35:0] pa32;
  logic err32;
  ksd_seg_t seg64;
  logic map64;
  logic cac64;
  logic [2:0] attr64;
  logic [35:0] pa64;
  logic err64;
  logic rsv64;

  ksd_seg32 u_seg32 (
    .vaddr(vaddr),
    .seg(seg32),
    .mapped(map32),
    .cached(cac32),
    .paddr(pa32),
    .addr_err(err32)
  );

  ksd_seg64 u_seg64 (
    .vaddr(vaddr),
    .error_level_flag(error_level_flag),
    .k0_attr(st_q.k0_attr),
    .seg(seg64),
    .mapped(map64),
    .cached(cac64),
    .attr(attr64),
    .paddr(pa64),
    .addr_err(err64),
    .rsv_attr(rsv64)
  );

  // ************************************************************
  // next state
  // ************************************************************
  logic kernel;
  logic [`KSD_EV_W-1:0] events;
  ksd_seg_t seg_sel;
  logic map_sel;
  logic cac_sel;
  logic [2:0] attr_sel;
  logic [35:0] pa_sel;
  logic err_sel;
  logic rsv_sel;

  always_comb begin
    kernel = (privilege_field == `KSD_PRIV_KERNEL) ||
             exception_level_flag || error_level_flag;
    // mapped segments leave cacheability to the TLB entry
    if (kernel_wide_addressing) begin
      seg_sel = seg64;
      map_sel = map64;
      cac_sel = cac64;
      attr_sel = attr64;
      pa_sel = pa64;
      err_sel = err64;
      rsv_sel = rsv64;
    end else begin
      seg_sel = seg32;
      map_sel = map32;
      cac_sel = cac32;
      attr_sel = map32 ? 3'h0 : `KSD_ATTR_UNCACHED;
      pa_sel = pa32;
      err_sel = err32;
      rsv_sel = 1'b0;
    end
    // outside kernel mode nothing is decoded here
    if (!kernel) begin
      seg_sel = KSD_SEG_NONE;
      map_sel = 1'b0;
      cac_sel = 1'b0;
      attr_sel = 3'h0;
      pa_sel = 36'h0;
      err_sel = 1'b0;
      rsv_sel = 1'b0;
    end
    // an erroring access must not reach memory
    if (err_sel) begin
      map_sel = 1'b0;
      cac_sel = 1'b0;
      pa_sel = 36'h0;
    end

    events = '0;
    events[`KSD_EV_ADDR_ERR] = req_valid && err_sel;
    events[`KSD_EV_RSV_ATTR] = req_valid && rsv_sel;
    events[`KSD_EV_DEBUG_HIT] = req_valid && (seg_sel == KSD_SEG_DEBUG);
    events[`KSD_EV_NOT_KERNEL] = req_valid && !kernel;

    st_d = st_q;

    // response stage: all fields land together
    st_d.resp_valid = req_valid;
    if (req_valid) begin
      st_d.resp_kernel = kernel;
      st_d.seg = seg_sel;
      st_d.mapped = map_sel;
      st_d.cached = cac_sel;
      st_d.attr = attr_sel;
      st_d.paddr = pa_sel;
      st_d.vaddr = vaddr;
      st_d.space_id = address_space_identifier;
      st_d.addr_err = err_sel;
    end
    if (events[`KSD_EV_ADDR_ERR]) begin
      st_d.err_vaddr = vaddr;
    end

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        `KSD_OFS_MASK: st_d.mask = reg_wdata[`KSD_EV_W-1:0];
        `KSD_OFS_CONFIG: st_d.k0_attr = reg_wdata[2:0];
        default: begin
        end
      endcase
    end

    // register reads, data stands in the next cycle only
    st_d.rdata = 32'h0;
    if (reg_rd) begin
      case (reg_addr)
        `KSD_OFS_STATUS: st_d.rdata = {28'h0, st_q.status};
        `KSD_OFS_MASK: st_d.rdata = {28'h0, st_q.mask};
        `KSD_OFS_CONFIG: st_d.rdata = {29'h0, st_q.k0_attr};
        `KSD_OFS_ERRLO: st_d.rdata = st_q.err_vaddr[31:0];
        `KSD_OFS_ERRHI: st_d.rdata = st_q.err_vaddr[63:32];
        default: st_d.rdata = 32'h0;
      endcase
    end

    // read clears, but a new event in the same cycle survives
    if (reg_rd && reg_addr == `KSD_OFS_STATUS) begin
      st_d.status = events;
    end else begin
      st_d.status = st_q.status | events;
    end
    st_d.irq = |(st_d.status & st_d.mask);
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clock) begin
    if (!resetn) begin
      st_q <= '0;
      st_q.seg <= KSD_SEG_NONE;
      st_q.mask <= `KSD_RST_MASK;
      st_q.k0_attr <= `KSD_RST_K0;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata = st_q.rdata;
  assign irq = st_q.irq;
  assign resp_valid = st_q.resp_valid;
  assign resp_kernel = st_q.resp_kernel;
  assign resp_segment = st_q.seg;
  assign resp_mapped = st_q.mapped;
  assign resp_cached = st_q.cached;
  assign resp_attr = st_q.attr;
  assign resp_paddr = st_q.paddr;
  assign resp_vaddr = st_q.vaddr;
  assign resp_space_id = st_q.space_id;
  assign resp_addr_error = st_q.addr_err;

endmodule

// ===== tb/ksd_top_props.sv
// checker of the kernel segment decoder response stage
`timescale 1ns/10ps
module ksd_top_props
  import ksd_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic req_valid,
  input wire logic [63:0] vaddr,
  input wire logic [1:0] privilege_field,
  input wire logic exception_level_flag,
  input wire logic error_level_flag,
  input wire logic kernel_wide_addressing,
  input wire logic [7:0] address_space_identifier,
  input wire logic resp_valid,
  input wire logic resp_kernel,
  input ksd_seg_t resp_segment,
  input wire logic resp_mapped,
  input wire logic resp_cached,
  input wire logic [2:0] resp_attr,
  input wire logic [35:0] resp_paddr,
  input wire logic [7:0] resp_space_id,
  input wire logic resp_addr_error
);
  wire logic k = req_valid && (privilege_field == 2'h0 ||
    exception_level_flag || error_level_flag);
  wire logic k32 = k && !kernel_wide_addressing && &vaddr[63:32];
  wire logic k64 = k && kernel_wide_addressing;
  wire logic ph = k64 && vaddr[63:62] == 2'h2;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  resp_pulse_a: assert property (resp_valid == $past(req_valid))
    else $error("response pulse not one cycle after request");
  kernel_flag_a: assert property (req_valid |=>
    resp_kernel == $past(k)) else $error("kernel mode misjudged");
  unc32_win_a: assert property (k32 && vaddr[31:29] == 3'h5 |=>
    resp_segment == KSD_SEG_UNCACHED32 && !resp_mapped && !resp_cached &&
    resp_paddr == {7'h0, $past(vaddr[28:0])}) else $error("uncached window");
  map32_win_a: assert property (k32 && vaddr[31:30] == 2'h3 &&
    vaddr[31:22] != 10'h3fc |=> resp_mapped && resp_paddr == 36'h0 &&
    resp_space_id == $past(address_space_identifier)) else $error("mapped 32");
  debug_win_a: assert property (k && vaddr[63:22] == {32'hffff_ffff,
    10'h3fc} |=> resp_segment == KSD_SEG_DEBUG && !resp_mapped &&
    !resp_cached) else $error("debug window not unmapped uncached");
  phys_err_a: assert property (ph && |vaddr[58:36] |=>
    resp_addr_error && !resp_mapped && resp_paddr == 36'h0)
    else $error("no address error");
  phys_win_a: assert property (ph && vaddr[58:36] == 23'h0 |=>
    !resp_mapped && !resp_addr_error && resp_paddr == $past(vaddr[35:0]) &&
    resp_attr == $past(vaddr[61:59]) &&
    resp_cached == (resp_attr inside {3'h0, 3'h1, 3'h3}))
    else $error("physical window decode");
  xmap_win_a: assert property (k64 && vaddr[61:40] == 22'h0 &&
    vaddr[63:62] != 2'h2 && !(vaddr[63:62] == 2'h0 && error_level_flag) &&
    !(vaddr[63:62] == 2'h3 && &vaddr[39:31]) |=> resp_mapped &&
    resp_space_id == $past(address_space_identifier)) else $error("mapped 64");
  errlvl_user_a: assert property (k64 && error_level_flag &&
    vaddr[63:31] == 33'h0 |=> resp_segment == KSD_SEG_XUSER_ERL &&
    !resp_mapped && !resp_cached && resp_paddr == $past(vaddr[35:0]))
    else $error("error level user window");
  compat_unc_a: assert property (k64 &&
    vaddr[63:29] == {32'hffff_ffff, 3'h5} |=> resp_segment == KSD_SEG_CK1 &&
    !resp_mapped && !resp_cached) else $error("second compat window");
  cover property (ph ##1 resp_valid);
  cover property (k64 && error_level_flag ##1 !resp_mapped);
  cover property (k32 ##1 resp_mapped);
endmodule
bind ksd_top ksd_top_props props_u (.clock, .resetn, .req_valid, .vaddr,
  .privilege_field, .exception_level_flag, .error_level_flag,
  .kernel_wide_addressing, .address_space_identifier, .resp_valid,
  .resp_kernel, .resp_segment, .resp_mapped, .resp_cached, .resp_attr,
  .resp_paddr, .resp_space_id, .resp_addr_error);

// ===== tb/ksd_tlb_sink.sv
// model of the tlb and cache side taking decoder answers
`timescale 1ns/10ps
module ksd_tlb_sink (
  input wire logic clock,
  input wire logic resetn,
  input wire logic resp_valid,
  output int n_resp
);
  // one answer per pulse; a stretched pulse would count twice
  always @(posedge clock) begin
    if (!resetn)
      n_resp <= 0;
    else if (resp_valid)
      n_resp <= n_resp + 1;
  end
endmodule

// ===== tb/ksd_top_tb.sv
// self-checking bench of the kernel segment decoder
`timescale 1ns/10ps
`include "ksd_cfg.svh"
module ksd_top_tb
  import ksd_pkg::*;
;
  localparam logic [4:0] K32 = 5'h00;
  localparam logic [4:0] K64 = 5'h10;
  logic clock, resetn, req_valid, exception_level_flag, error_level_flag;
  logic kernel_wide_addressing, reg_wr, reg_rd, irq, resp_valid, resp_kernel;
  logic resp_mapped, resp_cached, resp_addr_error;
  logic [1:0] privilege_field;
  logic [2:0] resp_attr;
  logic [7:0] address_space_identifier, reg_addr, resp_space_id;
  logic [31:0] reg_wdata, reg_rdata;
  logic [35:0] resp_paddr;
  logic [63:0] vaddr, resp_vaddr, phys_va;
  ksd_seg_t resp_segment;
  int mismatches = 0;
  int n_compared = 0;
  int n_req = 0;
  int n_resp;
  ksd_top dut_u (.clock, .resetn, .req_valid, .vaddr, .privilege_field,
    .exception_level_flag, .error_level_flag, .kernel_wide_addressing,
    .address_space_identifier, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .irq, .resp_valid, .resp_kernel, .resp_segment, .resp_mapped,
    .resp_cached, .resp_attr, .resp_paddr, .resp_vaddr, .resp_space_id,
    .resp_addr_error);
  ksd_tlb_sink sink_u (.clock, .resetn, .resp_valid, .n_resp);
  always #25 clock = ~clock;
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic dec(input logic [63:0] a, input logic [4:0] m,
    input logic mp, ca, er, input logic [35:0] pa);
    @(posedge clock);
    req_valid <= 1'b1;
    vaddr <= a;
    {kernel_wide_addressing, error_level_flag, exception_level_flag,
      privilege_field} <= m;
    address_space_identifier <= a[7:0] ^ 8'h5a;
    @(posedge clock);
    req_valid <= 1'b0;
    #1;
    n_req++;
    chk(resp_valid, 1'b1);
    chk(resp_mapped, mp);
    chk(resp_cached, ca);
    chk(resp_addr_error, er);
    chk(resp_paddr, pa);
    chk(resp_vaddr, a);
    chk(resp_space_id, a[7:0] ^ 8'h5a);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  task automatic report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (4000) @(posedge clock);
    mismatches++;
    report_and_stop();
  end
  initial begin
    {clock, resetn, req_valid, reg_wr, reg_rd} = 5'h0;
    {exception_level_flag, error_level_flag, kernel_wide_addressing} = 3'h0;
    {privilege_field, address_space_identifier, reg_addr} = 18'h0;
    {vaddr, reg_wdata} = 96'h0;
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    #1;
    chk(resp_segment, KSD_SEG_NONE);
    rd(`KSD_OFS_MASK, 32'h0);
    rd(`KSD_OFS_CONFIG, 32'h2);
    dec(64'hffff_ffff_a000_1234, K32, 0, 0, 0, 36'h1234);
    chk(resp_segment, KSD_SEG_UNCACHED32);
    dec(64'hffff_ffff_c000_0010, 5'h06, 1, 0, 0, 0);
    chk(resp_segment, KSD_SEG_SUPER32);
    dec(64'hffff_ffff_e000_0000, 5'h09, 1, 0, 0, 0);
    chk(resp_segment, KSD_SEG_MAPPED3_32);
    dec(64'hffff_ffff_ff3f_fff0, K32, 0, 0, 0, 36'hff3ffff0);
    chk(resp_segment, KSD_SEG_DEBUG);
    dec(64'hffff_ffff_ff00_0000, K64, 0, 0, 0, 36'hff000000);
    chk(resp_segment, KSD_SEG_DEBUG);
    dec(64'hffff_ffff_ff40_0000, K64, 1, 0, 0, 0);
    chk(resp_segment, KSD_SEG_CK3);
    dec(64'h0000_00ff_ffff_fff8, K64, 1, 0, 0, 0);
    chk(resp_segment, KSD_SEG_XUSER);
    dec(64'h0000_0100_0000_0000, K64, 0, 0, 1, 0);
    dec(64'h7fff_fff0, 5'h1b, 0, 0, 0, 36'h7ffffff0);
    chk(resp_segment, KSD_SEG_XUSER_ERL);
    dec(64'h8000_0000, 5'h1b, 1, 0, 0, 0);
    chk(resp_segment, KSD_SEG_XUSER);
    dec(64'h4000_0000_0000_0100, K64, 1, 0, 0, 0);
    chk(resp_segment, KSD_SEG_XSUPER);
    dec(64'hc000_00ff_7fff_fff0, K64, 1, 0, 0, 0);
    chk(resp_segment, KSD_SEG_XKERNEL);
    dec(64'hc000_00ff_8000_0000, K64, 0, 0, 1, 0);
    dec(64'hffff_ffff_8000_0040, K64, 0, 0, 0, 36'h40);
    chk(resp_segment, KSD_SEG_CK0);
    chk(resp_attr, 3'h2);
    dec(64'hffff_ffff_a000_1000, K64, 0, 0, 0, 36'h1000);
    chk(resp_segment, KSD_SEG_CK1);
    chk(resp_attr, 3'h2);
    dec(64'hffff_ffff_c000_0000, K64, 1, 0, 0, 0);
    chk(resp_segment, KSD_SEG_CKSUPER);
    for (int i = 0; i < 8; i++) begin
      phys_va = {2'h2, i[2:0], 23'h0, 36'h123456789};
      dec(phys_va, K64, 0, i inside {0, 1, 3}, 0, phys_va[35:0]);
      chk(resp_segment, KSD_SEG_XPHYS);
      chk(resp_attr, i[2:0]);
    end
    dec(64'h8000_0010_0000_0000, K64, 0, 0, 1, 0);
    chk(resp_segment, KSD_SEG_XPHYS);
    rd(`KSD_OFS_ERRHI, 32'h8000_0010);
    wr(`KSD_OFS_CONFIG, 32'h3);
    dec(64'hffff_ffff_8000_0040, K64, 0, 1, 0, 36'h40);
    chk(resp_segment, KSD_SEG_CK0);
    rd(`KSD_OFS_STATUS, 32'h7);
    chk(irq, 1'b0);
    wr(`KSD_OFS_MASK, 32'h8);
    dec(64'h0, 5'h02, 0, 0, 0, 0);
    chk(resp_segment, KSD_SEG_NONE);
    chk(resp_kernel, 1'b0);
    chk(irq, 1'b1);
    rd(`KSD_OFS_STATUS, 32'h8);
    chk(irq, 1'b0);
    dec(64'h8000_0010_0000_0000, K64, 0, 0, 1, 0);
    chk(irq, 1'b0);
    rd(8'h40, 32'h0);
    chk(n_resp, n_req);
    report_and_stop();
  end
endmodule
